// File: src/csp_clock_select.sv
module csp_clock_select (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [1:0] i_clock_source_select,
    input wire logic i_vco_bypass_flag,
    input wire logic [csp_pkg::CSP_DIV_W-1:0] i_output_divider_value,
    input wire logic i_osc_source_select,
    input wire logic i_external_clock_pin_input,
    input wire logic i_crystal_input_pin,
    input wire logic i_internal_clock_source,
    input wire logic i_wakeup_clock,
    input wire logic i_pll_clock,
    output logic o_system_clock,
    output logic o_switch_busy,
    output logic [1:0] o_active_source
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [csp_pkg::CSP_NUM_PINS-1:0] pins;
    logic [csp_pkg::CSP_NUM_PINS-1:0] sync1_r;
    logic [csp_pkg::CSP_NUM_PINS-1:0] sync2_r;

    assign pins = {i_pll_clock, i_wakeup_clock, i_internal_clock_source,
                   i_crystal_input_pin, i_external_clock_pin_input};

    genvar g;
    generate
        for (g = 0; g < csp_pkg::CSP_NUM_PINS; g++) begin : g_sync
            always_ff @(posedge i_clk or negedge i_nrst) begin
                if (!i_nrst) begin
                    sync1_r[g] <= 1'b0;
                    sync2_r[g] <= 1'b0;
                end else begin
                    sync1_r[g] <= pins[g];
                    sync2_r[g] <= sync1_r[g];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    csp_div_if dif ();
    logic cur_osc_r;

    // oscillator follows the committed choice so the divider never swaps mid-run
    assign dif.osc_level = cur_osc_r ? sync2_r[csp_pkg::CSP_PIN_INT]
                                     : sync2_r[csp_pkg::CSP_PIN_XTAL]; // RQ3
    assign dif.div_value = i_output_divider_value;

    csp_prescaler u_prescaler (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .dif(dif)
    );

    // ------------------------------------------------------------
    // source decode and level of a source
    // ------------------------------------------------------------
    function automatic csp_pkg::csp_src_t decode_src(input logic [1:0] sel, input logic byp);
        csp_pkg::csp_src_t s;
        s = csp_pkg::CSP_SRC_WAKE;
        if (sel == csp_pkg::CSP_SEL_DIRECT) begin
            s = csp_pkg::CSP_SRC_DIRECT; // RQ1
        end else if (sel == csp_pkg::CSP_SEL_PLL_PRE) begin
            s = byp ? csp_pkg::CSP_SRC_PRESCALE : csp_pkg::CSP_SRC_PLL; // RQ2 RQ8
        end
        // 00 and the unused 01 both fall back to the wakeup clock
        return s; // RQ7
    endfunction : decode_src

    function automatic logic level_of(input csp_pkg::csp_src_t s,
                                      input logic [csp_pkg::CSP_NUM_PINS-1:0] v,
                                      input logic dv);
        logic l;
        l = 1'b0;
        unique case (s)
            csp_pkg::CSP_SRC_WAKE: l = v[csp_pkg::CSP_PIN_WAKE];
            csp_pkg::CSP_SRC_DIRECT: l = v[csp_pkg::CSP_PIN_EXT];
            csp_pkg::CSP_SRC_PRESCALE: l = dv;
            csp_pkg::CSP_SRC_PLL: l = v[csp_pkg::CSP_PIN_PLL];
        endcase
        return l;
    endfunction : level_of

    // ------------------------------------------------------------
    // glitch-free switch
    // ------------------------------------------------------------
    csp_pkg::csp_state_t state_r, state_nxt;
    csp_pkg::csp_src_t cur_src_r, cur_src_nxt, tgt_src_r, tgt_src_nxt, req_src;
    logic cur_osc_nxt;
    logic tgt_osc_r;
    logic tgt_osc_nxt;
    logic cur_level;
    logic sys_r;
    logic sys_nxt;
    logic change;

    assign req_src = decode_src(i_clock_source_select, i_vco_bypass_flag);
    assign cur_level = level_of(cur_src_r, sync2_r, dif.div_clk);
    assign change = (req_src != cur_src_r) ||
                    (req_src == csp_pkg::CSP_SRC_PRESCALE && i_osc_source_select != cur_osc_r);

    always_comb begin
        state_nxt = state_r;
        cur_src_nxt = cur_src_r;
        cur_osc_nxt = cur_osc_r;
        tgt_src_nxt = tgt_src_r;
        tgt_osc_nxt = tgt_osc_r;
        sys_nxt = 1'b0;
        unique case (state_r)
            csp_pkg::CSP_ST_RUN: begin
                sys_nxt = cur_level; // RQ1 RQ7 RQ8
                if (change) begin
                    tgt_src_nxt = req_src;
                    tgt_osc_nxt = i_osc_source_select;
                    state_nxt = csp_pkg::CSP_ST_PARK_OLD;
                end
            end
            csp_pkg::CSP_ST_PARK_OLD: begin
                // let the running high phase finish, then hold low
                sys_nxt = cur_level & sys_r; // RQ8
                if (!cur_level) begin
                    cur_src_nxt = tgt_src_r;
                    cur_osc_nxt = tgt_osc_r;
                    state_nxt = csp_pkg::CSP_ST_WAIT_NEW;
                end
            end
            csp_pkg::CSP_ST_WAIT_NEW: begin
                // joining mid-high would emit a short pulse, so wait for low
                if (!cur_level) begin
                    state_nxt = csp_pkg::CSP_ST_RUN; // RQ8
                end
            end
            default: begin
                // unused state code: recover to run on the committed source
                state_nxt = csp_pkg::CSP_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_r <= csp_pkg::CSP_ST_RUN;
            cur_src_r <= csp_pkg::CSP_RST_SRC;
            cur_osc_r <= csp_pkg::CSP_RST_OSC;
            tgt_src_r <= csp_pkg::CSP_RST_SRC;
            tgt_osc_r <= csp_pkg::CSP_RST_OSC;
            sys_r <= 1'b0;
            o_switch_busy <= 1'b0;
            o_active_source <= 2'h0;
        end else begin
            state_r <= state_nxt;
            cur_src_r <= cur_src_nxt;
            cur_osc_r <= cur_osc_nxt;
            tgt_src_r <= tgt_src_nxt;
            tgt_osc_r <= tgt_osc_nxt;
            sys_r <= sys_nxt;
            o_switch_busy <= (state_nxt != csp_pkg::CSP_ST_RUN);
            o_active_source <= cur_src_nxt;
        end
    end

    assign o_system_clock = sys_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [2:0] run_cnt_r;
    logic steady;
    logic unity_div;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            run_cnt_r <= 3'h0;
        end else if (state_r != csp_pkg::CSP_ST_RUN) begin
            run_cnt_r <= 3'h0;
        end else if (run_cnt_r != csp_pkg::CSP_RUN_SAT) begin
            run_cnt_r <= run_cnt_r + 3'h1;
        end
    end

    assign steady = (run_cnt_r == csp_pkg::CSP_RUN_SAT) && (state_r == csp_pkg::CSP_ST_RUN);
    assign unity_div = (i_output_divider_value == 10'h000);

    AST_DIRECT: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ1
        (steady && cur_src_r == csp_pkg::CSP_SRC_DIRECT)
            |-> (o_system_clock == $past(i_external_clock_pin_input, 3)))
        else $error("direct drive does not follow the external clock pin");

    AST_WAKE: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ7
        (steady && cur_src_r == csp_pkg::CSP_SRC_WAKE)
            |-> (o_system_clock == $past(i_wakeup_clock, 3)))
        else $error("wakeup mode does not follow the wakeup clock");

    AST_PLL: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ8
        (steady && cur_src_r == csp_pkg::CSP_SRC_PLL)
            |-> (o_system_clock == $past(i_pll_clock, 3)))
        else $error("pll mode does not pass the pll clock");

    AST_PRE_XTAL: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ2
        (steady && cur_src_r == csp_pkg::CSP_SRC_PRESCALE && !cur_osc_r && unity_div
            && $past(i_output_divider_value, 2) == 10'h000)
            |-> (o_system_clock == $past(i_crystal_input_pin, 4)))
        else $error("prescaler does not take the crystal clock");

    AST_PRE_INT: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ3
        (steady && cur_src_r == csp_pkg::CSP_SRC_PRESCALE && cur_osc_r && unity_div
            && $past(i_output_divider_value, 2) == 10'h000)
            |-> (o_system_clock == $past(i_internal_clock_source, 4)))
        else $error("prescaler does not take the internal clock");

    sequence s_park_done;
        state_r == csp_pkg::CSP_ST_PARK_OLD && !cur_level;
    endsequence

    AST_SWITCH_LOW: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ8
        s_park_done |=> !o_system_clock throughout
            (state_r == csp_pkg::CSP_ST_WAIT_NEW)[*1])
        else $error("system clock not held low while joining the new source");

    AST_NO_SHORT_HIGH: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ8
        (state_r == csp_pkg::CSP_ST_PARK_OLD && !sys_r) |=> !o_system_clock)
        else $error("system clock rose while the old source was parked");

endmodule : csp_clock_select

// File: src/csp_pkg.sv
// What this block does
// RQ1: selector 11 runs the system clock straight from the external clock pin.
// RQ2: selector 10 with vco bypass flag 1 divides the oscillator clock.
// RQ3: prescaler oscillator is either the crystal input or the internal source.
// RQ4: division factor is divider value plus one; system clock is oscillator over it.
// RQ5: factor 1 passes the oscillator through, keeping its own duty cycle.
// RQ6: factors reach 1024, giving oscillator frequency over 1024 as the slowest clock.
// RQ7: selector 00 runs the system clock from the wakeup clock, undivided.
// RQ8: selector 10 with bypass 0 passes the pll clock; source changes never shorten a pulse.
package csp_pkg;

    // ------------------------------------------------------------
    // selector codes and field widths
    // ------------------------------------------------------------
    localparam logic [1:0] CSP_SEL_WAKEUP = 2'h0;
    localparam logic [1:0] CSP_SEL_PLL_PRE = 2'h2;
    localparam logic [1:0] CSP_SEL_DIRECT = 2'h3;
    localparam int CSP_DIV_W = 10;
    localparam int CSP_NUM_PINS = 5;

    // ------------------------------------------------------------
    // positions of the clock pins in the synchroniser vector
    // ------------------------------------------------------------
    localparam int CSP_PIN_EXT = 0;
    localparam int CSP_PIN_XTAL = 1;
    localparam int CSP_PIN_INT = 2;
    localparam int CSP_PIN_WAKE = 3;
    localparam int CSP_PIN_PLL = 4;

    // ------------------------------------------------------------
    // types and reset values
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CSP_SRC_WAKE,
        CSP_SRC_DIRECT,
        CSP_SRC_PRESCALE,
        CSP_SRC_PLL
    } csp_src_t;

    typedef enum logic [1:0] {
        CSP_ST_RUN,
        CSP_ST_PARK_OLD,
        CSP_ST_WAIT_NEW
    } csp_state_t;

    localparam csp_src_t CSP_RST_SRC = CSP_SRC_WAKE;
    localparam logic CSP_RST_OSC = 1'h0;
    localparam logic [CSP_DIV_W-1:0] CSP_RST_CNT = 10'h000;
    localparam logic [2:0] CSP_RUN_SAT = 3'h7;

endpackage : csp_pkg

// File: src/csp_div_if.sv
interface csp_div_if;
    logic osc_level;
    logic [csp_pkg::CSP_DIV_W-1:0] div_value;
    logic div_clk;

    modport ctrl (output osc_level, output div_value, input div_clk);
    modport div (input osc_level, input div_value, output div_clk);
endinterface : csp_div_if

// File: src/csp_prescaler.sv
module csp_prescaler (
    input wire logic i_clk,
    input wire logic i_nrst,
    csp_div_if.div dif
);

    logic prev_r;
    logic [csp_pkg::CSP_DIV_W-1:0] cnt_r;
    logic [csp_pkg::CSP_DIV_W-1:0] cnt_nxt;
    logic out_r;
    logic out_nxt;
    logic rise;
    logic wrap;
    logic [csp_pkg::CSP_DIV_W:0] half;

    // ------------------------------------------------------------
    // divider: counts oscillator rising edges, factor = value + 1
    // ------------------------------------------------------------
    assign rise = dif.osc_level & ~prev_r;
    assign wrap = rise && (cnt_r >= dif.div_value);
    // high for the first half of the period, odd factors high one longer
    assign half = ({1'b0, dif.div_value} + 11'h002) >> 1;

    always_comb begin
        cnt_nxt = cnt_r;
        if (wrap) begin
            cnt_nxt = csp_pkg::CSP_RST_CNT; // RQ4
        end else if (rise) begin
            cnt_nxt = cnt_r + 10'h001;
        end
        if (dif.div_value == csp_pkg::CSP_RST_CNT) begin
            out_nxt = dif.osc_level; // RQ5
        end else begin
            out_nxt = ({1'b0, cnt_nxt} < half); // RQ4 RQ6
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            prev_r <= 1'b0;
            cnt_r <= csp_pkg::CSP_RST_CNT;
            out_r <= 1'b0;
        end else begin
            prev_r <= dif.osc_level;
            cnt_r <= cnt_nxt;
            out_r <= out_nxt;
        end
    end

    assign dif.div_clk = out_r;

    // ------------------------------------------------------------
    // checks: period in oscillator edges equals the factor
    // ------------------------------------------------------------
    logic [csp_pkg::CSP_DIV_W:0] seen_r;
    logic k_chg_r;
    logic [csp_pkg::CSP_DIV_W-1:0] k_last_r;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            seen_r <= 11'h000;
            k_chg_r <= 1'b1;
            k_last_r <= csp_pkg::CSP_RST_CNT;
        end else begin
            k_last_r <= dif.div_value;
            if (wrap) begin
                seen_r <= 11'h000;
                k_chg_r <= 1'b0;
            end else begin
                if (rise) begin
                    seen_r <= seen_r + 11'h001;
                end
                if (dif.div_value != k_last_r) begin
                    k_chg_r <= 1'b1;
                end
            end
        end
    end

    AST_DIV_PERIOD: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ4
        (wrap && !k_chg_r && dif.div_value == k_last_r)
            |-> (seen_r + 11'h001 == {1'b0, dif.div_value} + 11'h001))
        else $error("prescaler period differs from the division factor");

    AST_DIV_MAX: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ6
        (wrap && !k_chg_r && dif.div_value == 10'h3ff) |-> (seen_r == 11'h3ff))
        else $error("largest factor does not give 1024 oscillator periods");

    AST_DIV_RISE: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ4
        (wrap && dif.div_value != 10'h000) |=> $rose(out_r))
        else $error("divided clock did not rise at the period start");

    AST_DIV_ONE: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ5
        (dif.div_value == 10'h000) |=> (out_r == $past(dif.osc_level)))
        else $error("factor one does not pass the oscillator through");

endmodule : csp_prescaler

// File: bench/csp_clk_gen.sv
module csp_clk_gen #(
    parameter int HI = 2,
    parameter int LO = 2
) (
    input wire logic i_clk,
    output logic o_clk
);
    timeunit 1ns;
    timeprecision 100ps;

    int cnt;

    // --------------------------------------------------------
    // free running source clock
    // --------------------------------------------------------
    // oscillators never stop, so no idle level is modelled
    initial begin
        o_clk = 1'b0;
        cnt = 0;
    end

    always @(negedge i_clk) begin
        cnt = cnt + 1;
        if (cnt >= (o_clk ? HI : LO)) begin
            o_clk = ~o_clk;
            cnt = 0;
        end
    end
endmodule : csp_clk_gen

// File: bench/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int WH = 7, WL = 7, EH = 2, EL = 4, XH = 2, XL = 3;
    localparam int IH = 4, IL = 6, PH = 3, PL = 3;

    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic [1:0] sel = 2'h0;
    logic byp = 1'b0;
    logic [csp_pkg::CSP_DIV_W-1:0] div = 10'h000;
    logic osel = 1'b0;
    logic ext, xtal, intc, wake, pll, sys, busy;
    logic [1:0] act;
    int mismatches = 0;
    int n_tests = 0;
    int cyc = 0;
    int run = 0;
    logic sys_prev = 1'b0;

    always #2 i_clk = ~i_clk;

    csp_clk_gen #(.HI(EH), .LO(EL)) u_gen_ext (.i_clk(i_clk), .o_clk(ext));
    csp_clk_gen #(.HI(XH), .LO(XL)) u_gen_xtal (.i_clk(i_clk), .o_clk(xtal));
    csp_clk_gen #(.HI(IH), .LO(IL)) u_gen_int (.i_clk(i_clk), .o_clk(intc));
    csp_clk_gen #(.HI(WH), .LO(WL)) u_gen_wake (.i_clk(i_clk), .o_clk(wake));
    csp_clk_gen #(.HI(PH), .LO(PL)) u_gen_pll (.i_clk(i_clk), .o_clk(pll));

    csp_clock_select u_csp_clock_select (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_clock_source_select(sel),
        .i_vco_bypass_flag(byp), .i_output_divider_value(div),
        .i_osc_source_select(osel), .i_external_clock_pin_input(ext),
        .i_crystal_input_pin(xtal), .i_internal_clock_source(intc),
        .i_wakeup_clock(wake), .i_pll_clock(pll), .o_system_clock(sys),
        .o_switch_busy(busy), .o_active_source(act)
    );

    // --------------------------------------------------------
    // compare and closing tasks
    // --------------------------------------------------------
    task automatic chk_val(input logic [1:0] got, input logic [1:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_len(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_len

    task automatic test_done;
        $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done

    // hang guard: longest divided period is about 5k cycles
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 80000) begin
            mismatches++;
            test_done;
        end
    end

    // no high or low phase of the output may be shorter than the shortest source phase
    always @(negedge i_clk) begin
        if (i_nrst !== 1'b1) begin
            run = 0;
        end else if (sys === sys_prev) begin
            run++;
        end else begin
            if (run != 0) chk_val({1'b0, 1'(run >= 2)}, 2'h1);
            run = 1;
        end
        sys_prev = sys;
    end

    // --------------------------------------------------------
    // helpers
    // --------------------------------------------------------
    task automatic measure(output logic [15:0] hi, output logic [15:0] lo);
        hi = 16'h0000;
        lo = 16'h0000;
        @(negedge i_clk);
        while (sys !== 1'b0) @(negedge i_clk);
        while (sys !== 1'b1) @(negedge i_clk);
        while (sys === 1'b1) begin
            hi = hi + 16'h0001;
            @(negedge i_clk);
        end
        while (sys === 1'b0) begin
            lo = lo + 16'h0001;
            @(negedge i_clk);
        end
    endtask : measure

    // first period after a change may be partial, so it is dropped
    task automatic check_clk(input int ehi, input int elo);
        logic [15:0] hi, lo;
        measure(hi, lo);
        measure(hi, lo);
        chk_len(hi, 16'(ehi));
        chk_len(lo, 16'(elo));
    endtask : check_clk

    task automatic switch_to(input logic [1:0] s, input logic b, input logic o,
                             input logic [1:0] exp_act);
        int n;
        sel = s;
        byp = b;
        osel = o;
        n = 0;
        while (busy !== 1'b1 && n < 4) begin
            @(negedge i_clk);
            n++;
        end
        chk_val({1'b0, busy}, 2'h1);
        while (busy === 1'b1) @(negedge i_clk);
        chk_val(act, exp_act);
    endtask : switch_to

    // --------------------------------------------------------
    // scenarios
    // --------------------------------------------------------
    task automatic t_reset;
        chk_val({busy, sys}, 2'h0);
        chk_val(act, 2'h0);
    endtask : t_reset

    task automatic t_wake;
        check_clk(WH, WL);
    endtask : t_wake

    task automatic t_direct;
        switch_to(2'h3, 1'b0, 1'b0, 2'h1);
        check_clk(EH, EL);
    endtask : t_direct

    task automatic t_presc;
        switch_to(2'h2, 1'b1, 1'b0, 2'h2);
        check_clk(XH, XL);
        div = 10'h002;
        check_clk(2 * (XH + XL), XH + XL);
        div = 10'h001;
        check_clk(XH + XL, XH + XL);
        div = 10'h3ff;
        check_clk(512 * (XH + XL), 512 * (XH + XL));
        div = 10'h000;
    endtask : t_presc

    task automatic t_internal;
        switch_to(2'h2, 1'b1, 1'b1, 2'h2);
        check_clk(IH, IL);
        div = 10'h002;
        check_clk(2 * (IH + IL), IH + IL);
    endtask : t_internal

    task automatic t_pll;
        switch_to(2'h2, 1'b0, 1'b1, 2'h3);
        check_clk(PH, PL);
    endtask : t_pll

    task automatic t_back;
        switch_to(2'h1, 1'b0, 1'b0, 2'h0);
        check_clk(WH, WL);
    endtask : t_back

    initial begin
        repeat (16) @(negedge i_clk);
        t_reset;
        i_nrst = 1'b1;
        t_wake;
        t_direct;
        t_presc;
        t_internal;
        t_pll;
        t_back;
        test_done;
    end
endmodule : tb_top
